// ==== verilog/timer_map.vh ====
/*
  Register offsets, field positions, reset values and codes of the
  16-bit capture/compare timer. Assumes an APB slave with 8-bit byte address.
*/
// Function
// - First match may slip one count clock
// - Capture proceeds during read; read value undefined
// - Valid edges interrupt; reverse-phase edge does not
// - Capture/compare contents undefined after stop
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// Register byte offsets
`define OFF_CTRL     8'h00
`define OFF_COUNT    8'h04
`define OFF_CCA      8'h08
`define OFF_CCB      8'h0c
`define OFF_STAT     8'h10
`define OFF_MASK     8'h14
`define OFF_OUT      8'h18

// Control fields
`define B_RUN        0
`define B_MODE_LO    1
`define B_MODE_HI    2
`define B_CAPEN      3
`define B_EDGA_LO    4
`define B_EDGA_HI    5
`define B_EDGB_LO    6
`define B_EDGB_HI    7
`define B_EXTCLK     8
`define B_OSTRIG     9
`define B_LVSET      10
`define B_LVRST      11
`define CTRL_W       9
`define CTRL_RST     9'h000

// Modes
`define MODE_FREE    2'h0
`define MODE_CLRA    2'h1
`define MODE_ONESHOT 2'h2

// Edge select codes
`define EDGE_FALL    2'h0
`define EDGE_RISE    2'h1
`define EDGE_BOTH    2'h2

// Status / mask bits
`define S_IRQA       0
`define S_IRQB       1
`define S_OVF        2
`define STAT_W       3
`define STAT_RST     3'h0

// Counter reset value and maximum count
`define CNT_RST      16'h0000
`define CNT_MAX      16'hffff

`endif

// ==== verilog/pin_edge.v ====
/*
  Pin synchroniser and edge classifier for one timer input.
  Assumes the pin is asynchronous to pclk; edges shorter than two clocks may be missed.
*/
`timescale 1ns/10ps
`include "timer_map.vh"
module pin_edge
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Pin and edge choice
  input  wire       pin,
  input  wire [1:0] sel,
  // Edge events
  output reg        valid_edge,
  output reg        rev_edge
);
  reg  s1;
  reg  s2;
  reg  s3;
  wire rise;
  wire fall;

  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1         <= 1'b0;
      s2         <= 1'b0;
      s3         <= 1'b0;
      valid_edge <= 1'b0;
      rev_edge   <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      case (sel)
        `EDGE_FALL:
        begin
          valid_edge <= fall;
          rev_edge   <= rise;
        end
        `EDGE_RISE:
        begin
          valid_edge <= rise;
          rev_edge   <= fall;
        end
        `EDGE_BOTH:
        begin
          valid_edge <= rise | fall;
          rev_edge   <= 1'b0;
        end
        default:
        begin
          valid_edge <= 1'b0;
          rev_edge   <= 1'b0;
        end
      endcase
    end
  end
endmodule // pin_edge

// ==== verilog/timer_capcomp.v ====
/*
  16-bit timer/event counter with two capture/compare registers, one-shot
  output, clear-on-match, sticky interrupts and an APB register slave.
  Assumes a single pclk domain; the input pins are asynchronous to it.
*/
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "timer_map.vh"
module timer_capcomp
#(
  parameter PRE_W = 2
)
(
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timer pins
  input  wire        timer_input_a_pin,
  input  wire        timer_input_b_pin,
  output reg         timer_out,
  // Interrupt
  output reg         irq
);
  reg  [`CTRL_W-1:0] ctrl;
  reg  [15:0]        timer_count_reg;
  reg  [15:0]        capcomp_reg_a;
  reg  [15:0]        capcomp_reg_b;
  reg  [`STAT_W-1:0] stat;
  reg  [`STAT_W-1:0] mask;
  reg  [PRE_W-1:0]   pre;
  reg                os_active;
  reg  [`STAT_W-1:0] next_stat;
  reg  [31:0]        next_rdata;
  reg                next_err;
  wire               a_valid;
  wire               a_rev;
  wire               b_valid;
  wire               acc;
  wire               wr;
  wire               run;
  wire [1:0]         mode;
  wire               cap_en;
  wire               oneshot_soft_trigger;
  wire               output_level_set;
  wire               output_level_reset;
  wire               trigger;
  wire               tick;
  wire               cpulse;
  wire               counting;
  wire               match_a;
  wire               match_b;
  wire               capcomp_a_irq;
  wire               capcomp_b_irq;
  wire               ovf;
  wire               ctrl_wr;
  wire               cca_wr;
  wire               ccb_wr;
  wire               stat_wr;
  wire               mask_wr;
  wire               acc_first;
  wire               cap_a;
  wire               cap_b;
  wire               clr_match;
  wire               set_match;

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  function mode_is;
    input [1:0] cur;
    input [1:0] want;
    begin
      mode_is = (cur == want);
    end
  endfunction

  pin_edge u_edge_a
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (timer_input_a_pin),
    .sel        (ctrl[`B_EDGA_HI:`B_EDGA_LO]),
    .valid_edge (a_valid),
    .rev_edge   (a_rev)
  );

  pin_edge u_edge_b
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (timer_input_b_pin),
    .sel        (ctrl[`B_EDGB_HI:`B_EDGB_LO]),
    .valid_edge (b_valid),
    .rev_edge   ()
  );

  // One wait state: the write lands on the edge where pready is seen high
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign run    = ctrl[`B_RUN];
  assign mode   = ctrl[`B_MODE_HI:`B_MODE_LO];
  assign cap_en = ctrl[`B_CAPEN];

  // Per-register write strobes, each qualified by the completing access
  assign ctrl_wr = wr & hit(paddr, `OFF_CTRL);
  assign cca_wr  = wr & hit(paddr, `OFF_CCA);
  assign ccb_wr  = wr & hit(paddr, `OFF_CCB);
  assign stat_wr = wr & hit(paddr, `OFF_STAT);
  assign mask_wr = wr & hit(paddr, `OFF_MASK);

  // First access cycle: the answer is prepared here and shown in the next
  assign acc_first = psel & penable & ~pready;

  // Self-clearing command bits; they read back as zero
  assign oneshot_soft_trigger = ctrl_wr & pwdata[`B_OSTRIG];
  assign output_level_set     = ctrl_wr & pwdata[`B_LVSET];
  assign output_level_reset   = ctrl_wr & pwdata[`B_LVRST];

  // Steady input A is the caller's duty when only the soft trigger is meant
  assign trigger = run & mode_is(mode, `MODE_ONESHOT) & (oneshot_soft_trigger | a_valid);

  // Free-running prescaler, so a start lands anywhere within a count period
  assign tick     = (pre == {PRE_W{1'b0}});
  assign cpulse   = ctrl[`B_EXTCLK] ? a_valid : tick;
  // A one-shot counts only between its trigger and match A
  assign counting = run & cpulse & (~mode_is(mode, `MODE_ONESHOT) | os_active);

  // Compare only outside capture mode; a zero compare A value stalls clear mode
  assign match_a = counting & ~cap_en & (timer_count_reg == capcomp_reg_a);
  assign match_b = counting & ~cap_en & (timer_count_reg == capcomp_reg_b);
  assign ovf     = counting & (timer_count_reg == `CNT_MAX);

  // Reverse-phase edge on A captures silently, without an interrupt
  assign capcomp_a_irq = cap_en ? (run & b_valid) : match_a;
  assign capcomp_b_irq = cap_en ? (run & a_valid) : match_b;

  // Valid B or reverse A loads A; valid A loads B
  assign cap_a = run & cap_en & (b_valid | a_rev);
  assign cap_b = run & cap_en & a_valid;

  // Free-running mode ignores both matches for the counter and the output
  assign clr_match = match_a & ~mode_is(mode, `MODE_FREE);
  assign set_match = match_b & ~mode_is(mode, `MODE_FREE);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre <= {PRE_W{1'b0}};
    else
      pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
  end

  // Control and mask registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `CTRL_RST;
      mask <= `STAT_RST;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= pwdata[`CTRL_W-1:0];
      if (mask_wr)
        mask <= pwdata[`STAT_W-1:0];
    end
  end

  // Counter and one-shot state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_count_reg <= `CNT_RST;
      os_active       <= 1'b0;
    end
    else if (!run)
    begin
      timer_count_reg <= `CNT_RST;
      os_active       <= 1'b0;
    end
    else if (trigger)
    begin
      timer_count_reg <= `CNT_RST;
      os_active       <= 1'b1;
    end
    // Clear mode restarts from zero at match A; a one-shot clears to zero and stops
    else if (clr_match)
    begin
      timer_count_reg <= `CNT_RST;
      os_active       <= 1'b0;
    end
    else if (counting)
      timer_count_reg <= timer_count_reg + 16'h0001;
  end

  // Captures take priority over software writes and are never held off by reads
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capcomp_reg_a <= `CNT_RST;
      capcomp_reg_b <= `CNT_RST;
    end
    else
    begin
      if (cap_a)
        capcomp_reg_a <= timer_count_reg;
      else if (cca_wr)
        capcomp_reg_a <= pwdata[15:0];
      if (cap_b)
        capcomp_reg_b <= timer_count_reg;
      else if (ccb_wr)
        capcomp_reg_b <= pwdata[15:0];
    end
  end

  // Output: on at match B, off at match A, or forced by the level commands
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_out <= 1'b0;
    else if (output_level_set)
      timer_out <= 1'b1;
    else if (output_level_reset || !run)
      timer_out <= 1'b0;
    else if (clr_match)
      timer_out <= 1'b0;
    else if (set_match)
      timer_out <= 1'b1;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always @*
  begin
    next_stat = stat;
    if (stat_wr)
      next_stat = stat & ~pwdata[`STAT_W-1:0];
    next_stat[`S_IRQA] = next_stat[`S_IRQA] | capcomp_a_irq;
    next_stat[`S_IRQB] = next_stat[`S_IRQB] | capcomp_b_irq;
    next_stat[`S_OVF]  = next_stat[`S_OVF] | ovf;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat <= `STAT_RST;
      irq  <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      irq  <= |(next_stat & mask);
    end
  end

  // Read mux; capture values after a stop are whatever was last held
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr)
      `OFF_CTRL:  next_rdata[`CTRL_W-1:0] = ctrl;
      `OFF_COUNT: next_rdata[15:0] = timer_count_reg;
      `OFF_CCA:   next_rdata[15:0] = capcomp_reg_a;
      `OFF_CCB:   next_rdata[15:0] = capcomp_reg_b;
      `OFF_STAT:  next_rdata[`STAT_W-1:0] = stat;
      `OFF_MASK:  next_rdata[`STAT_W-1:0] = mask;
      `OFF_OUT:   next_rdata[0] = timer_out;
      // Misaligned and unmapped offsets are refused
      default:    next_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc_first;
      pslverr <= acc_first & next_err;
      // Read data changes only on a read, so it holds between transfers
      if (acc_first && !pwrite)
        prdata <= next_rdata;
    end
  end
endmodule // timer_capcomp

// ==== testbench/timer_capcomp_assertions.sv ====
/* Concurrent checks on the ports of timer_capcomp.
   Assumes one pclk domain and asynchronous active-low presetn. */
`timescale 1ns/10ps
module timer_capcomp_checker
(
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pins and interrupt
  input wire        timer_input_a_pin,
  input wire        timer_input_b_pin,
  input wire        timer_out,
  input wire        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

  property p_err_unmapped;
    psel && penable && pready && paddr > 8'h18 |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  property p_read_ok;
    psel && penable && pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("mapped access refused");

  property p_rdata_hold;
    $changed(prdata) |-> pready && !pwrite;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved outside a read");

  // Bit 10 would set the output on purpose, so it is left out
  property p_stop_out;
    psel && penable && pready && pwrite && paddr == 8'h00 && !pwdata[0] && !pwdata[10] |-> ##[1:2] !timer_out;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("output high after stop");
endmodule // timer_capcomp_checker

bind timer_capcomp timer_capcomp_checker i_timer_capcomp_checker
(
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input_a_pin(timer_input_a_pin), .timer_input_b_pin(timer_input_b_pin),
  .timer_out(timer_out), .irq(irq)
);

// ==== testbench/pin_source.sv ====
/* Signal source for the two timer input pins.
   Assumes pclk is the timer clock; pins move only on command. */
`timescale 1ns/10ps
module pin_source
(
  // Clock
  input  wire  pclk,
  // Timer input pins
  output logic pin_a,
  output logic pin_b
);
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // Levels are held between commands, so no stray trigger reaches input A
  task drive(input logic a, input logic b);
    @(posedge pclk);
    pin_a <= a;
    pin_b <= b;
    // Held well past the two-clock minimum so no edge is lost
    repeat (6) @(posedge pclk);
  endtask
endmodule // pin_source

// ==== testbench/tb.sv ====
/* Self-checking testbench for timer_capcomp.
   Assumes pin_source drives the pins and the checker is bound. */
`timescale 1ns/10ps
module tb;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] pwdata      = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         pa;
  wire         pb;
  wire         tout;
  wire         irq;
  logic [31:0] rd;
  logic        er;
  logic [15:0] ccb1;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          n;
  int          m;

  always #20 pclk = ~pclk;

  timer_capcomp #(.PRE_W(2)) i_timer_capcomp
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_a_pin(pa), .timer_input_b_pin(pb), .timer_out(tout), .irq(irq)
  );
  pin_source i_pin_source (.pclk(pclk), .pin_a(pa), .pin_b(pb));

  task wrap_up;
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never drives psel twice in a time step
    @(posedge pclk);
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(nm, e, rd[15:0]);
  endtask

  task t_regs;
    rchk("ctrl", 8'h00, 16'h0000);
    apb(1'b1, 8'h14, 16'hffff);
    rchk("mask", 8'h14, 16'h0007);
    rchk("unmapped", 8'h1c, 16'h0000);
    chk("slverr", 16'h0001, {15'h0000, er});
  endtask

  task t_capture;
    apb(1'b1, 8'h00, 16'h0059);
    i_pin_source.drive(1'b0, 1'b1);
    rchk("stat_valid_b", 8'h10, 16'h0001);
    chk("irq_set", 16'h0001, {15'h0000, irq});
    apb(1'b1, 8'h10, 16'h0007);
    i_pin_source.drive(1'b1, 1'b1);
    rchk("stat_valid_a", 8'h10, 16'h0002);
    apb(1'b0, 8'h0c, 16'h0000);
    ccb1 = rd[15:0];
    apb(1'b1, 8'h10, 16'h0007);
    i_pin_source.drive(1'b0, 1'b1);
    rchk("stat_reverse", 8'h10, 16'h0000);
    chk("irq_clear", 16'h0000, {15'h0000, irq});
    // Valid, reverse, valid on input A while capture register A is read
    fork
      repeat (8) apb(1'b0, 8'h08, 16'h0000);
      begin
        i_pin_source.drive(1'b1, 1'b1);
        i_pin_source.drive(1'b0, 1'b1);
        i_pin_source.drive(1'b1, 1'b1);
      end
    join
    rchk("stat_during_read", 8'h10, 16'h0002);
    apb(1'b0, 8'h0c, 16'h0000);
    chk("ccb_recapture", 16'h0001, {15'h0000, rd[15:0] > ccb1});
    apb(1'b1, 8'h10, 16'h0007);
    apb(1'b1, 8'h14, 16'h0000);
    i_pin_source.drive(1'b0, 1'b0);
    i_pin_source.drive(1'b0, 1'b1);
    rchk("stat_masked", 8'h10, 16'h0001);
    chk("irq_masked", 16'h0000, {15'h0000, irq});
  endtask

  task t_match;
    apb(1'b1, 8'h00, 16'h0000);
    apb(1'b1, 8'h08, 16'h000a);
    apb(1'b1, 8'h0c, 16'h0005);
    apb(1'b1, 8'h00, 16'h0003);
    n = 0;
    while (tout !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    // Match B takes six count pulses of four clocks; the first lands one to four clocks after start
    chk("first_match", 16'h0001, {15'h0000, n >= 21 && n <= 24});
  endtask

  task t_oneshot;
    apb(1'b1, 8'h00, 16'h0000);
    apb(1'b1, 8'h08, 16'h0008);
    apb(1'b1, 8'h0c, 16'h0002);
    apb(1'b1, 8'h00, 16'h0005);
    apb(1'b1, 8'h10, 16'h0007);
    apb(1'b1, 8'h00, 16'h0205);
    n = 0;
    while (tout !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    // Match B after three count pulses, the first one to four clocks after the trigger
    chk("os_delay", 16'h0001, {15'h0000, n >= 9 && n <= 12});
    m = 0;
    while (tout === 1'b1 && m < 100)
    begin
      @(posedge pclk);
      m++;
    end
    // High from match B to match A: six count pulses of four clocks
    chk("os_width", 16'h0018, m[15:0]);
    rchk("os_count", 8'h04, 16'h0000);
    rchk("os_stat", 8'h10, 16'h0003);
    apb(1'b1, 8'h00, 16'h0405);
    rchk("out_set", 8'h18, 16'h0001);
    apb(1'b1, 8'h00, 16'h0805);
    rchk("out_reset", 8'h18, 16'h0000);
  endtask

  task t_extcount;
    apb(1'b1, 8'h00, 16'h0000);
    apb(1'b1, 8'h00, 16'h0121);
    i_pin_source.drive(1'b1, 1'b1);
    i_pin_source.drive(1'b0, 1'b1);
    rchk("ext_count", 8'h04, 16'h0002);
  endtask

  task t_stop;
    apb(1'b1, 8'h00, 16'h0000);
    rchk("count_stopped", 8'h04, 16'h0000);
    chk("out_stopped", 16'h0000, {15'h0000, tout});
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_capture;
    t_match;
    t_oneshot;
    t_extcount;
    t_stop;
    wrap_up;
  end
endmodule // tb
